// ### core/ahd_ports.sv
// high-address port and data-bus port with mode-dependent pin ownership
// assumes a single-cycle internal cpu bus with registered read data,
// a static mode strap and standby levels from the same clock domain
//
// Overview of operation
// R1: mode 1 drives address byte on port 2
// R2: mode 2 port 2 per-pin input or address
// R3: mode 3 port 2 is plain gpio
// R4: direction bit 1 output, 0 input
// R5: direction registers read back all ones
// R6: mode 1 port 2 direction fixed ones
// R7: port 2 input pull-up follows data bit
// R8: port 2 pull-ups off for outputs, mode 1
// R9: reset clears port 2; mode 1 sets ones
// R10: hardware standby floats port 2, pull-ups off
// R11: soft standby: address pins low, gpio held
// R12: soft standby pull-ups follow data bits
// R13: modes 1, 2 port 3 is data bus
// R14: mode 3 port 3 gpio or handshake
// R15: port 3 pull-ups only mode 3 inputs
// R16: latch mode captures on strobe fall, holds
// R17: latch off passes data through
// R18: reset, hw standby clear port 3
// R19: soft standby port 3 retained, bus floats
// R20: data read gives latch or pin level
// R21: latched port 3 inputs read held value
`timescale 1ns/1ns
`default_nettype none
module ahd_ports
  import ahd_pkg::*;
(
  // clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst,
  // internal cpu bus
  input  wire ahd_pkg::ahd_addr_t cpu_addr,
  input  wire logic          cpu_wr,
  input  wire logic          cpu_rd,
  input  wire ahd_pkg::ahd_byte_t cpu_wdata,
  output var  ahd_pkg::ahd_byte_t cpu_rdata,
  // mode strap and power state
  input  wire logic [1:0]    mode_pins,
  input  wire logic          hw_standby,
  input  wire logic          sw_standby,
  // expansion bus controller
  input  wire ahd_pkg::ahd_byte_t bus_addr_hi,
  input  wire ahd_pkg::ahd_byte_t bus_data_out,
  input  wire logic          bus_data_drive,
  output var  ahd_pkg::ahd_byte_t bus_data_in,
  // handshake control
  input  wire logic          input_latch_enable_bit,
  input  wire logic          input_strobe_n,
  // port 2 pins
  input  wire ahd_pkg::ahd_byte_t p2_pin_in,
  output var  ahd_pkg::ahd_byte_t p2_pin_out,
  output var  ahd_pkg::ahd_byte_t p2_pin_oe_n,
  output var  ahd_pkg::ahd_byte_t p2_pullup,
  // port 3 pins
  input  wire ahd_pkg::ahd_byte_t p3_pin_in,
  output var  ahd_pkg::ahd_byte_t p3_pin_out,
  output var  ahd_pkg::ahd_byte_t p3_pin_oe_n,
  output var  ahd_pkg::ahd_byte_t p3_pullup
);
  import ahd_pkg::*;

  // registers
  ahd_byte_t high_addr_port_direction_r;
  ahd_byte_t high_addr_port_data_r;
  ahd_byte_t data_bus_port_direction_r;
  ahd_byte_t data_bus_port_data_r;
  logic [1:0] mode_r;
  logic       strap_taken_r;

  // filtered pins
  logic [AHD_SYNC_W-1:0] pins_stable;
  ahd_byte_t p2_sync;
  ahd_byte_t p3_sync;
  logic      strobe_sync_n;

  ahd_pin_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .raw      ({input_strobe_n, p3_pin_in, p2_pin_in}),
    .stable   (pins_stable)
  );

  assign p2_sync       = pins_stable[7:0];
  assign p3_sync       = pins_stable[15:8];
  assign strobe_sync_n = pins_stable[16];

  // mode decode
  wire mode1 = (mode_r == AHD_MODE_EXP_NOROM);
  wire mode2 = (mode_r == AHD_MODE_EXP_ROM);
  wire mode3 = ~mode1 & ~mode2;

  // address decode
  wire sel_p2_dir  = (cpu_addr == AHD_P2_DIR_OFS);
  wire sel_p2_data = (cpu_addr == AHD_P2_DATA_OFS);
  wire sel_p3_dir  = (cpu_addr == AHD_P3_DIR_OFS);
  wire sel_p3_data = (cpu_addr == AHD_P3_DATA_OFS);
  wire wr_p2_dir   = cpu_wr & sel_p2_dir;
  wire wr_p2_data  = cpu_wr & sel_p2_data;
  wire wr_p3_dir   = cpu_wr & sel_p3_dir;
  wire wr_p3_data  = cpu_wr & sel_p3_data;

  // strobe latch link; handshake is off outside mode 3 and in hw standby
  ahd_latch_if lk ();
  assign lk.pin_data = p3_sync;
  assign lk.strobe_n = strobe_sync_n;
  assign lk.latch_en = input_latch_enable_bit & mode3 & ~hw_standby; // R14 R18
  assign lk.read_ack = cpu_rd & sel_p3_data;

  ahd_strobe_latch u_latch (
    .core_clk (core_clk),
    .rst      (rst),
    .lk       (lk)
  );

  // next register values
  ahd_byte_t p2_dir_nxt;
  ahd_byte_t p2_data_nxt;
  ahd_byte_t p3_dir_nxt;
  ahd_byte_t p3_data_nxt;
  assign p2_dir_nxt  = mode1 ? AHD_P2_DIR_MODE1 :                // R6 R9
                       (wr_p2_dir ? cpu_wdata : high_addr_port_direction_r);
  assign p2_data_nxt = wr_p2_data ? cpu_wdata : high_addr_port_data_r;
  assign p3_dir_nxt  = hw_standby ? AHD_DIR_RST :                // R18
                       (wr_p3_dir ? cpu_wdata : data_bus_port_direction_r);
  assign p3_data_nxt = hw_standby ? AHD_DATA_RST :               // R18
                       (wr_p3_data ? cpu_wdata : data_bus_port_data_r);

  // the strap is caught after release, never under the async reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r        <= AHD_MODE_SINGLE;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      mode_r        <= mode_pins;
      strap_taken_r <= 1'b1;
    end
  end

  // register file; contents kept through soft standby
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      high_addr_port_direction_r <= AHD_DIR_RST;  // R9
      high_addr_port_data_r      <= AHD_DATA_RST; // R9
      data_bus_port_direction_r  <= AHD_DIR_RST;  // R18
      data_bus_port_data_r       <= AHD_DATA_RST; // R18
    end else begin
      high_addr_port_direction_r <= p2_dir_nxt;   // R11 R19
      high_addr_port_data_r      <= p2_data_nxt;
      data_bus_port_direction_r  <= p3_dir_nxt;
      data_bus_port_data_r       <= p3_data_nxt;
    end
  end

  // port 2 pin ownership
  ahd_byte_t p2_addr_pin;
  ahd_byte_t p2_out_nxt;
  ahd_byte_t p2_oe_nxt;
  ahd_byte_t p2_pu_nxt;
  ahd_byte_t p2_addr_val;
  assign p2_addr_pin = mode1 ? AHD_ALL_ONE :                       // R1
                       (mode2 ? high_addr_port_direction_r : AHD_ALL_ZERO); // R2 R3
  assign p2_addr_val = sw_standby ? AHD_ALL_ZERO : bus_addr_hi;     // R11
  assign p2_out_nxt  = (p2_addr_pin & p2_addr_val) |
                       (~p2_addr_pin & high_addr_port_data_r);      // R11
  assign p2_oe_nxt   = hw_standby ? AHD_ALL_ZERO :                  // R10
                       (high_addr_port_direction_r | p2_addr_pin);   // R4
  // pull-ups only on mode 2/3 inputs, held through soft standby
  assign p2_pu_nxt   = (hw_standby | mode1) ? AHD_ALL_ZERO :        // R8 R10
                       (~high_addr_port_direction_r & high_addr_port_data_r); // R7 R12

  // port 3 pin ownership: data bus in modes 1/2, gpio in mode 3
  ahd_byte_t p3_out_nxt;
  ahd_byte_t p3_oe_nxt;
  ahd_byte_t p3_pu_nxt;
  wire       bus_drive = bus_data_drive & ~sw_standby;              // R19
  assign p3_out_nxt = mode3 ? data_bus_port_data_r : bus_data_out;  // R13
  assign p3_oe_nxt  = hw_standby ? AHD_ALL_ZERO :                   // R18
                      (mode3 ? data_bus_port_direction_r :          // R4 R14
                       {8{bus_drive}});                             // R13
  assign p3_pu_nxt  = (hw_standby | ~mode3) ? AHD_ALL_ZERO :        // R15
                      (~data_bus_port_direction_r & data_bus_port_data_r); // R15

  // read mux: direction registers are invisible
  ahd_byte_t p2_rd_val;
  ahd_byte_t p3_rd_val;
  ahd_byte_t rd_nxt;
  assign p2_rd_val = (high_addr_port_direction_r & high_addr_port_data_r) |
                     (~high_addr_port_direction_r & p2_sync);       // R20
  assign p3_rd_val = (data_bus_port_direction_r & data_bus_port_data_r) |
                     (~data_bus_port_direction_r & lk.data);        // R20 R21
  assign rd_nxt    = (sel_p2_dir | sel_p3_dir) ? AHD_DIR_READBACK : // R5
                     sel_p2_data ? p2_rd_val :
                     sel_p3_data ? p3_rd_val : AHD_ALL_ZERO;

  // every output leaves a flop; pins follow settings one cycle later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpu_rdata   <= AHD_ALL_ZERO;
      bus_data_in <= AHD_ALL_ZERO;
      p2_pin_out  <= AHD_ALL_ZERO;
      p2_pin_oe_n <= AHD_ALL_ONE;
      p2_pullup   <= AHD_ALL_ZERO;
      p3_pin_out  <= AHD_ALL_ZERO;
      p3_pin_oe_n <= AHD_ALL_ONE;
      p3_pullup   <= AHD_ALL_ZERO;
    end else begin
      cpu_rdata   <= cpu_rd ? rd_nxt : AHD_ALL_ZERO;
      bus_data_in <= p3_sync;
      p2_pin_out  <= p2_out_nxt;
      p2_pin_oe_n <= ~p2_oe_nxt;
      p2_pullup   <= p2_pu_nxt;
      p3_pin_out  <= p3_out_nxt;
      p3_pin_oe_n <= ~p3_oe_nxt;
      p3_pullup   <= p3_pu_nxt;
    end
  end

  // checks on the pin and register behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_mode1_addr_drive: assert property ( // R1
    strap_taken_r && mode1 && !hw_standby && !sw_standby
      |=> (p2_pin_oe_n == AHD_ALL_ZERO) && (p2_pin_out == $past(bus_addr_hi)))
    else $error("mode 1 port 2 not driving address");

  a_dir_readback: assert property ( // R5
    cpu_rd && (sel_p2_dir || sel_p3_dir) |=> cpu_rdata == AHD_DIR_READBACK)
    else $error("direction register read not all ones");

  a_mode1_dir_fixed: assert property ( // R6
    mode1 && strap_taken_r |=> high_addr_port_direction_r == AHD_P2_DIR_MODE1)
    else $error("mode 1 port 2 direction not all ones");

  a_p2_dir_oe: assert property ( // R4
    mode3 && !hw_standby && !$past(hw_standby)
      |-> p2_pin_oe_n == ~$past(high_addr_port_direction_r))
    else $error("port 2 enable does not follow direction");

  a_p2_pullup_rule: assert property ( // R7
    !mode1 && !hw_standby
      |=> p2_pullup == $past(~high_addr_port_direction_r & high_addr_port_data_r))
    else $error("port 2 pull-up mismatch");

  a_hw_float: assert property ( // R10
    hw_standby |=> (p2_pin_oe_n == AHD_ALL_ONE) && (p3_pin_oe_n == AHD_ALL_ONE)
                   && (p2_pullup == AHD_ALL_ZERO) && (p3_pullup == AHD_ALL_ZERO))
    else $error("hardware standby left a pin driven");

  a_hw_clear_p3: assert property ( // R18
    hw_standby |=> data_bus_port_direction_r == AHD_DIR_RST
                   && data_bus_port_data_r == AHD_DATA_RST)
    else $error("hardware standby kept port 3 registers");

  a_sw_addr_low: assert property ( // R11
    sw_standby && mode1 && !hw_standby |=> p2_pin_out == AHD_ALL_ZERO)
    else $error("address pins not low in soft standby");

  a_sw_bus_float: assert property ( // R19
    sw_standby && !mode3 |=> p3_pin_oe_n == AHD_ALL_ONE)
    else $error("data bus driven in soft standby");

  a_p3_pullup_mode: assert property ( // R15
    !mode3 |=> p3_pullup == AHD_ALL_ZERO)
    else $error("port 3 pull-up on outside mode 3");

  a_p2_out_read: assert property ( // R20
    cpu_rd && sel_p2_data && high_addr_port_direction_r == AHD_ALL_ONE
      |=> cpu_rdata == $past(high_addr_port_data_r))
    else $error("port 2 output read not from latch");

  // mode 2 address pins carry the bus byte, enables follow direction
  a_p2_mode2_addr: assert property ( // R2
    mode2 && !hw_standby && !sw_standby
      |=> ((p2_pin_out & $past(high_addr_port_direction_r))
           == ($past(bus_addr_hi) & $past(high_addr_port_direction_r)))
          && (~p2_pin_oe_n == $past(high_addr_port_direction_r)))
    else $error("mode 2 port 2 address pins wrong");

  a_p3_bus_owned: assert property ( // R13
    !mode3 |=> p3_pin_out == $past(bus_data_out))
    else $error("port 3 not carrying bus data outside mode 3");

  a_p3_pullup_rule: assert property ( // R15
    mode3 && !hw_standby
      |=> p3_pullup == $past(~data_bus_port_direction_r & data_bus_port_data_r))
    else $error("port 3 pull-up mismatch in mode 3");

  // first falling strobe while empty takes the pin byte
  a_latch_capture: assert property ( // R16
    lk.latch_en && !u_latch.held_r && $fell(lk.strobe_n)
      |=> u_latch.held_r && (u_latch.hold_r == $past(lk.pin_data)))
    else $error("strobe fall did not capture port 3 data");

  a_latch_hold: assert property ( // R16
    u_latch.held_r |=> $stable(u_latch.hold_r))
    else $error("held port 3 data changed before read");

  c_mode2_mixed: cover property (mode2 && high_addr_port_direction_r == 8'h0f);
  c_latch_capture: cover property (lk.latch_en && $fell(strobe_sync_n));
  c_sw_standby_m3: cover property (sw_standby && mode3 && p3_pin_oe_n != AHD_ALL_ONE);
  c_hw_standby: cover property (hw_standby ##1 !hw_standby);
endmodule
`default_nettype wire

// ### core/ahd_pkg.sv
// package for the high-address and data-bus port pair
// assumes an 8-bit cpu data path and a 16-bit internal address space
package ahd_pkg;

  typedef logic [7:0]  ahd_byte_t;
  typedef logic [15:0] ahd_addr_t;

  // register offsets on the internal cpu bus
  localparam ahd_addr_t AHD_P2_DIR_OFS  = 16'hffb1;
  localparam ahd_addr_t AHD_P2_DATA_OFS = 16'hffb3;
  localparam ahd_addr_t AHD_P3_DIR_OFS  = 16'hffb4;
  localparam ahd_addr_t AHD_P3_DATA_OFS = 16'hffb6;

  // reset and forced values
  localparam ahd_byte_t AHD_DIR_RST      = 8'h00;
  localparam ahd_byte_t AHD_DATA_RST     = 8'h00;
  localparam ahd_byte_t AHD_P2_DIR_MODE1 = 8'hff;
  localparam ahd_byte_t AHD_DIR_READBACK = 8'hff;
  localparam ahd_byte_t AHD_ALL_ZERO     = 8'h00;
  localparam ahd_byte_t AHD_ALL_ONE      = 8'hff;

  // mode strap encodings
  localparam logic [1:0] AHD_MODE_EXP_NOROM = 2'h1;
  localparam logic [1:0] AHD_MODE_EXP_ROM   = 2'h2;
  localparam logic [1:0] AHD_MODE_SINGLE    = 2'h3;

  // synchroniser width: port 2, port 3 and the strobe
  localparam int AHD_SYNC_W = 17;
  localparam logic [AHD_SYNC_W-1:0] AHD_SYNC_RST = 17'h10000;

endpackage

// ### core/ahd_latch_if.sv
// carrier between the port core and the port 3 strobe latch
// assumes both ends run on core_clk
`timescale 1ns/1ns
`default_nettype none
interface ahd_latch_if;
  import ahd_pkg::*;
  ahd_byte_t pin_data;   // filtered port 3 pin levels
  logic      strobe_n;   // filtered input strobe, active low
  logic      latch_en;   // latch mode, already gated by mode
  logic      read_ack;   // cpu read of port 3 data
  ahd_byte_t data;       // held or passed-through data

  modport core  (output pin_data, strobe_n, latch_en, read_ack, input data);
  modport latch (input pin_data, strobe_n, latch_en, read_ack, output data);
endinterface
`default_nettype wire

// ### core/ahd_pin_sync.sv
// three-stage input filter for pins from outside the clock domain
// a bit changes once the second and third stages agree
`timescale 1ns/1ns
`default_nettype none
module ahd_pin_sync
  import ahd_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // raw pins and filtered levels
  input  wire logic [AHD_SYNC_W-1:0] raw,
  output var  logic [AHD_SYNC_W-1:0] stable
);
  logic [AHD_SYNC_W-1:0] s1_r;
  logic [AHD_SYNC_W-1:0] s2_r;
  logic [AHD_SYNC_W-1:0] s3_r;

  // s1_r feeds only s2_r, never the compare
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r   <= AHD_SYNC_RST;
      s2_r   <= AHD_SYNC_RST;
      s3_r   <= AHD_SYNC_RST;
      stable <= AHD_SYNC_RST;
    end else begin
      s1_r   <= raw;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      stable <= (s2_r & s3_r) | (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & stable);
    end
  end
endmodule
`default_nettype wire

// ### core/ahd_strobe_latch.sv
// port 3 input strobe latch
// strobe already filtered; latch_en already gated by mode
`timescale 1ns/1ns
`default_nettype none
module ahd_strobe_latch
  import ahd_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // link to the port core
  ahd_latch_if.latch lk
);
  logic      strobe_prev_r;
  logic      held_r;
  ahd_byte_t hold_r;
  wire       strobe_fall = strobe_prev_r & ~lk.strobe_n;
  wire       capture     = lk.latch_en & strobe_fall & ~held_r;

  // falling edge captures; later edges are ignored until the cpu reads
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strobe_prev_r <= 1'b1;
      held_r        <= 1'b0;
      hold_r        <= AHD_ALL_ZERO;
    end else begin
      strobe_prev_r <= lk.strobe_n;
      if (capture) begin
        hold_r <= lk.pin_data; // R16
      end
      held_r <= lk.latch_en & (capture | (held_r & ~lk.read_ack));
    end
  end

  // transparent when latch mode is off
  assign lk.data = lk.latch_en ? hold_r : lk.pin_data; // R17
endmodule
`default_nettype wire

// ### sim/ahd_far_pins.sv
// far-side model of one 8-pin port: outside drivers, pull-ups, floating pins
// assumes the bench commands the outside drivers on core_clk
`timescale 1ns/1ns
`default_nettype none
module ahd_far_pins
  import ahd_pkg::*;
(
  // clock
  input  wire logic               core_clk,
  // device side of the pins
  input  wire ahd_pkg::ahd_byte_t dev_out,
  input  wire ahd_pkg::ahd_byte_t dev_oe_n,
  input  wire ahd_pkg::ahd_byte_t pu_on,
  // outside driver set by the bench
  input  wire ahd_pkg::ahd_byte_t ext_en,
  input  wire ahd_pkg::ahd_byte_t ext_val,
  // resolved pin level
  output var  ahd_pkg::ahd_byte_t level
);
  ahd_byte_t wander_r = 8'h55;
  // floating pins change every cycle so a stale level cannot pass for a read
  always @(posedge core_clk) begin
    wander_r <= ~wander_r;
  end
  // device drive wins, then outside driver, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!dev_oe_n[i]) level[i] = dev_out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pu_on[i]) level[i] = 1'b1;
      else level[i] = wander_r[i];
    end
  end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the high-address and data-bus ports
// assumes ahd_ports and the far-side pin model; inputs change on falling edges
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ahd_pkg::*;
  logic      core_clk = 1'b0;
  logic      rst = 1'b1;
  ahd_addr_t cpu_addr;
  logic      cpu_wr, cpu_rd, hw_standby, sw_standby, bus_data_drive, in_latch_en, strobe_n;
  ahd_byte_t cpu_wdata, cpu_rdata, bus_addr_hi, bus_data_out, bus_data_in;
  logic [1:0] mode_pins;
  ahd_byte_t p2_in, p2_out, p2_oe_n, p2_pu, p3_in, p3_out, p3_oe_n, p3_pu;
  ahd_byte_t e2_en, e2_val, e3_en, e3_val;
  int        error_cnt = 0;
  int        n_compared = 0;

  // 100 MHz
  always #5 core_clk = ~core_clk;

  ahd_ports i_dut (.core_clk(core_clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .mode_pins(mode_pins),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .bus_addr_hi(bus_addr_hi),
    .bus_data_out(bus_data_out), .bus_data_drive(bus_data_drive), .bus_data_in(bus_data_in),
    .input_latch_enable_bit(in_latch_en), .input_strobe_n(strobe_n), .p2_pin_in(p2_in),
    .p2_pin_out(p2_out), .p2_pin_oe_n(p2_oe_n), .p2_pullup(p2_pu), .p3_pin_in(p3_in),
    .p3_pin_out(p3_out), .p3_pin_oe_n(p3_oe_n), .p3_pullup(p3_pu));
  ahd_far_pins i_far2 (.core_clk(core_clk), .dev_out(p2_out), .dev_oe_n(p2_oe_n),
    .pu_on(p2_pu), .ext_en(e2_en), .ext_val(e2_val), .level(p2_in));
  ahd_far_pins i_far3 (.core_clk(core_clk), .dev_out(p3_out), .dev_oe_n(p3_oe_n),
    .pu_on(p3_pu), .ext_en(e3_en), .ext_val(e3_val), .level(p3_in));

  task automatic wrap_up();
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input ahd_byte_t exp, input ahd_byte_t got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input ahd_addr_t a, input ahd_byte_t d);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge core_clk);
    cpu_wr = 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input ahd_addr_t a, output ahd_byte_t d);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge core_clk);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask

  task automatic settle();
    repeat (6) @(negedge core_clk);
  endtask

  task automatic chk_port(input string p, input ahd_byte_t dir, input ahd_byte_t dat,
                          input ahd_byte_t oe, input ahd_byte_t out, input ahd_byte_t pu);
    chk({p, " oe_n"}, ~dir, oe);
    chk({p, " out"}, dat & dir, out & dir);
    chk({p, " pullup"}, dat & ~dir, pu);
  endtask

  // output bits read the latch, inputs the pin; a bare input with pull-up reads 1
  function automatic ahd_byte_t exp_rd(ahd_byte_t dir, ahd_byte_t dat, ahd_byte_t ext,
                                       ahd_byte_t en);
    return (dat & dir) | (~dir & ((ext & en) | (~en & dat)));
  endfunction

  task automatic do_reset(input logic [1:0] m);
    rst = 1'b1;
    mode_pins = m;
    repeat (5) @(negedge core_clk);
    chk("p2 oe_n in reset", AHD_ALL_ONE, p2_oe_n);
    chk("p3 pullup in reset", AHD_ALL_ZERO, p3_pu);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  // hang guard
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    ahd_byte_t d2, q2, d3, q3, v, w;
    {cpu_addr, cpu_wr, cpu_rd, cpu_wdata, hw_standby, sw_standby} = '0;
    {bus_addr_hi, bus_data_out, bus_data_drive, in_latch_en} = '0;
    {e2_en, e2_val, e3_en, e3_val} = '0;
    strobe_n = 1'b1;
    mode_pins = 2'h3;
    v = $urandom(32'hc8064c76);
    do_reset(2'h3);
    rd(AHD_P2_DIR_OFS, v);
    chk("p2 dir read", AHD_DIR_READBACK, v);
    rd(AHD_P3_DIR_OFS, v);
    chk("p3 dir read", AHD_DIR_READBACK, v);
    chk_port("p2 after reset", 8'h00, 8'h00, p2_oe_n, p2_out, p2_pu);
    // single-chip gpio, random with corner cases
    for (int k = 0; k < 12; k++) begin
      {d2, q2, d3, q3, e2_en, e2_val, e3_en, e3_val} = {$urandom, $urandom};
      if (k == 0) {d2, q2, e2_en, d3, q3, e3_en} = 48'h00ff00_00ff00;
      if (k == 1) {d2, d3} = 16'hffff;
      wr(AHD_P2_DIR_OFS, d2);
      wr(AHD_P2_DATA_OFS, q2);
      wr(AHD_P3_DIR_OFS, d3);
      wr(AHD_P3_DATA_OFS, q3);
      settle();
      chk_port("p2", d2, q2, p2_oe_n, p2_out, p2_pu);
      chk_port("p3", d3, q3, p3_oe_n, p3_out, p3_pu);
      rd(AHD_P2_DATA_OFS, v);
      w = d2 | e2_en | q2;
      chk("p2 data read", exp_rd(d2, q2, e2_val, e2_en) & w, v & w);
      rd(AHD_P3_DATA_OFS, v);
      w = d3 | e3_en | q3;
      chk("p3 data read", exp_rd(d3, q3, e3_val, e3_en) & w, v & w);
    end
    sw_standby = 1'b1;
    settle();
    chk_port("p2 soft standby", d2, q2, p2_oe_n, p2_out, p2_pu);
    chk_port("p3 soft standby", d3, q3, p3_oe_n, p3_out, p3_pu);
    sw_standby = 1'b0;
    hw_standby = 1'b1;
    settle();
    chk("p2 oe_n hw standby", AHD_ALL_ONE, p2_oe_n);
    chk("p2 pullup hw standby", AHD_ALL_ZERO, p2_pu);
    chk("p3 oe_n hw standby", AHD_ALL_ONE, p3_oe_n);
    chk("p3 pullup hw standby", AHD_ALL_ZERO, p3_pu);
    hw_standby = 1'b0;
    settle();
    chk_port("p2 after hw standby", d2, q2, p2_oe_n, p2_out, p2_pu);
    chk_port("p3 after hw standby", 8'h00, 8'h00, p3_oe_n, p3_out, p3_pu);
    // strobe latch: first edge wins, held until read, then armed again
    in_latch_en = 1'b1;
    e3_en = 8'hff;
    {v, w} = 16'($urandom);
    e3_val = v;
    strobe_n = 1'b0;
    settle();
    strobe_n = 1'b1;
    e3_val = ~v;
    settle();
    strobe_n = 1'b0;
    settle();
    rd(AHD_P3_DATA_OFS, q3);
    chk("p3 latched read", v, q3);
    strobe_n = 1'b1;
    e3_val = w;
    settle();
    strobe_n = 1'b0;
    settle();
    e3_val = ~w;
    settle();
    rd(AHD_P3_DATA_OFS, q3);
    chk("p3 second capture", w, q3);
    strobe_n = 1'b1;
    in_latch_en = 1'b0;
    wr(16'hffb5, 8'h3c);
    rd(16'hffb5, v);
    chk("unmapped read", AHD_ALL_ZERO, v);
    // expanded with on-chip memory
    do_reset(2'h2);
    {bus_addr_hi, bus_data_out, d2, q2} = $urandom;
    bus_data_drive = 1'b1;
    wr(AHD_P2_DIR_OFS, d2);
    wr(AHD_P2_DATA_OFS, q2);
    wr(AHD_P3_DIR_OFS, 8'h0f);
    wr(AHD_P3_DATA_OFS, 8'hff);
    settle();
    chk("p2 oe_n mode 2", ~d2, p2_oe_n);
    chk("p2 address mode 2", bus_addr_hi & d2, p2_out & d2);
    chk("p2 pullup mode 2", q2 & ~d2, p2_pu);
    chk("p3 oe_n bus", AHD_ALL_ZERO, p3_oe_n);
    chk("p3 out bus", bus_data_out, p3_out);
    chk("p3 pullup bus", AHD_ALL_ZERO, p3_pu);
    sw_standby = 1'b1;
    settle();
    chk("p2 address low", AHD_ALL_ZERO, p2_out & d2);
    chk("p2 oe_n soft standby", ~d2, p2_oe_n);
    chk("p2 pullup soft standby", q2 & ~d2, p2_pu);
    chk("p3 float soft standby", AHD_ALL_ONE, p3_oe_n);
    sw_standby = 1'b0;
    bus_data_drive = 1'b0;
    e3_val = 8'($urandom);
    settle();
    chk("p3 oe_n bus idle", AHD_ALL_ONE, p3_oe_n);
    chk("bus data in", e3_val, bus_data_in);
    // expanded without on-chip memory
    do_reset(2'h1);
    bus_addr_hi = 8'($urandom);
    wr(AHD_P2_DIR_OFS, 8'h00);
    wr(AHD_P2_DATA_OFS, 8'hff);
    settle();
    chk("p2 oe_n mode 1", AHD_ALL_ZERO, p2_oe_n);
    chk("p2 address mode 1", bus_addr_hi, p2_out);
    chk("p2 pullup mode 1", AHD_ALL_ZERO, p2_pu);
    sw_standby = 1'b1;
    settle();
    chk("p2 address low mode 1", AHD_ALL_ZERO, p2_out);
    chk("p2 oe_n soft standby mode 1", AHD_ALL_ZERO, p2_oe_n);
    sw_standby = 1'b0;
    rd(AHD_P2_DIR_OFS, v);
    chk("p2 dir read mode 1", AHD_DIR_READBACK, v);
    wrap_up();
  end
endmodule
`default_nettype wire
